// ### core/brce_regs.vh
// Constants for the bar code and raster command engine
// Operation
// - Font command 00h selects 12x24 text font, 01h selects 8x16 font.
// - Human readable text under symbols always prints at 1x1 scale.
// - Height command takes 01h-FFh dots; reset height is 162 dots.
// - Symbology from first parameter: 43h EAN13, 45h CODE39, 46h ITF.
// - Length parameter counts data bytes; exactly that many are consumed.
// - Length outside symbology range abandons command; later bytes are normal data.
// - Any invalid data byte means feed paper only, later bytes normal data.
// - Symbol wider than printable width means feed paper only, no print.
// - After a symbol, feed the symbol's own height, ignoring line spacing.
// - Symbol command needs empty print buffer; else bytes after type are normal.
// - After printing a symbol, return to line start; print modes ignored.
// - ITF needs even count; odd count drops the last received byte.
// - Raster mode 00h-03h: normal, double width, double height, quadruple.
// - Raster width 1-128 bytes, height 1-2303 rows, data is width times height.
// - Raster command executes only with an empty print buffer.
// - Raster bytes beyond printable area are consumed and dropped.
// - Raster bit 1 prints a dot, bit 0 leaves it blank.
// - Raster image starts horizontally at the programmed left margin.
// - Width command takes 02h-06h module width; reset value is 03h.
// - Locked cutter enters error state and starts automatic recovery.
// - Text position command takes 00h none or 02h below symbol.
// - Left margin shifts text, raster graphics and symbols alike.
`ifndef BRCE_REGS_VH
`define BRCE_REGS_VH
// ==========================================
// Command bytes
`define BRCE_GS          8'h1d
`define BRCE_OP_FONT     8'h66
`define BRCE_OP_HEIGHT   8'h68
`define BRCE_OP_SYMBOL   8'h6b
`define BRCE_OP_RASTER   8'h76
`define BRCE_OP_RASTER0  8'h30
`define BRCE_OP_WIDTH    8'h77
`define BRCE_OP_POS      8'h48
`define BRCE_OP_MARGIN   8'h4c
`define BRCE_SYM_EAN13   8'h43
`define BRCE_SYM_CODE39  8'h45
`define BRCE_SYM_ITF     8'h46
// ==========================================
// Limits and geometry
`define BRCE_EAN_MIN     8'h0c
`define BRCE_EAN_MAX     8'h0d
`define BRCE_EAN_MODS    12'h05f
`define BRCE_C39_MODS    12'h00d
`define BRCE_ITF_MODS    12'h009
`define BRCE_WID_MIN     8'h02
`define BRCE_WID_MAX     8'h06
`define BRCE_RMODE_MAX   8'h03
`define BRCE_RWID_MAX    16'h0080
`define BRCE_RHGT_HMAX   8'h08
`define BRCE_RHGT_MAX    16'h0fff
`define BRCE_FONT_A_H    9'h018
`define BRCE_FONT_B_H    9'h010
// ==========================================
// Reset values
`define BRCE_RST_FONT    1'h0
`define BRCE_RST_HEIGHT  8'ha2
`define BRCE_RST_WIDTH   3'h3
`define BRCE_RST_BELOW   1'h1
`define BRCE_RST_MARGIN  16'h0000
// ==========================================
// Register offsets
`define BRCE_REG_STATUS  4'h0
`define BRCE_REG_FONT    4'h1
`define BRCE_REG_HEIGHT  4'h2
`define BRCE_REG_WIDTH   4'h3
`define BRCE_REG_POS     4'h4
`define BRCE_REG_MARG_L  4'h5
`define BRCE_REG_MARG_H  4'h6
`endif

// ### core/brce_engine.v
// Bar code and raster command interpreter
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`include "brce_regs.vh"
module brce_engine #(
  parameter PRINT_DOTS = 576
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [7:0]  rxByte,
  input  wire        rxValid,
  output reg         rxReady_r,
  input  wire        bufEmpty,
  input  wire        cutterLocked,
  input  wire        cutterHome,
  output reg  [7:0]  normByte_r,
  output reg         normValid_r,
  output reg         symStart_r,
  output reg  [7:0]  symType_r,
  output reg  [7:0]  symCount_r,
  output reg  [7:0]  symByte_r,
  output reg         symValid_r,
  output reg         feedReq_r,
  output reg  [8:0]  feedDots_r,
  output reg         homeReq_r,
  output reg  [7:0]  rasterDots_r,
  output reg  [15:0] rasterX_r,
  output reg  [11:0] rasterRow_r,
  output reg  [1:0]  rasterMode_r,
  output reg         rasterValid_r,
  output reg         hriFont_r,
  output reg         hriBelow_r,
  output reg  [7:0]  barHeight_r,
  output reg  [2:0]  moduleWidth_r,
  output reg  [15:0] leftMargin_r,
  output reg         errState_r,
  output reg         recoverReq_r,
  input  wire [3:0]  regAddr,
  input  wire [7:0]  regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [7:0]  regRdata_r
);

  // ==========================================
  // States
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_GS    = 4'h1;
  localparam [3:0] ST_ARG   = 4'h2;
  localparam [3:0] ST_MARGL = 4'h3;
  localparam [3:0] ST_MARGH = 4'h4;
  localparam [3:0] ST_SYMM  = 4'h5;
  localparam [3:0] ST_SYMN  = 4'h6;
  localparam [3:0] ST_SYMD  = 4'h7;
  localparam [3:0] ST_CHK   = 4'h8;
  localparam [3:0] ST_OUT   = 4'h9;
  localparam [3:0] ST_V0    = 4'ha;
  localparam [3:0] ST_RM    = 4'hb;
  localparam [3:0] ST_RXL   = 4'hc;
  localparam [3:0] ST_RXH   = 4'hd;
  localparam [3:0] ST_RYL   = 4'he;
  localparam [3:0] ST_RYH   = 4'hf;
  localparam [3:0] ST_RDAT  = 4'h0;

  localparam [19:0] PD = PRINT_DOTS[19:0];

  // ==========================================
  // Functions
  function charOk;
    input [7:0] sym;
    input [7:0] c;
    reg         dig;
    begin
      dig = (c >= 8'h30) && (c <= 8'h39);
      if (sym == `BRCE_SYM_CODE39) begin
        charOk = dig || ((c >= 8'h41) && (c <= 8'h5a)) ||
                 (c == 8'h20) || (c == 8'h24) || (c == 8'h25) ||
                 (c == 8'h2b) || (c == 8'h2d) || (c == 8'h2e) ||
                 (c == 8'h2f);
      end else begin
        charOk = dig;
      end
    end
  endfunction

  // ==========================================
  // State
  reg [3:0]  state_r;
  reg        inRaster_r;
  reg [7:0]  cmd_r;
  reg [7:0]  symLen_r;
  reg [7:0]  symIdx_r;
  reg        badData_r;
  reg [7:0]  symMem [0:255];
  reg [7:0]  rWidLo_r;
  reg [15:0] rWidth_r;
  reg [7:0]  rHgtLo_r;
  reg [7:0]  rCol_r;
  reg [11:0] rRow_r;
  reg        rDrop_r;
  reg [1:0]  lockSync_r;
  reg [1:0]  homeSync_r;

  wire       take = rxValid && rxReady_r;
  wire       rasterData = inRaster_r && (state_r == ST_RDAT);

  // ==========================================
  // Symbol geometry
  wire [7:0]  effLen = (symType_r == `BRCE_SYM_ITF) ? {symLen_r[7:1], 1'b0} : symLen_r;
  wire [11:0] lenW = {4'h0, effLen};
  wire [11:0] modCnt = (symType_r == `BRCE_SYM_EAN13) ? `BRCE_EAN_MODS :
                       (symType_r == `BRCE_SYM_CODE39) ? (lenW + 12'h002) * `BRCE_C39_MODS :
                       lenW * `BRCE_ITF_MODS + `BRCE_ITF_MODS;
  wire [19:0] extent = {4'h0, leftMargin_r} + {8'h00, modCnt} * {17'h00000, moduleWidth_r};
  wire        tooWide = extent > PD;
  // Feed covers bars plus text band; line spacing never enters
  wire [8:0]  textH = hriFont_r ? `BRCE_FONT_B_H : `BRCE_FONT_A_H;
  wire [8:0]  symFeed = {1'b0, barHeight_r} + (hriBelow_r ? textH : 9'h000);

  // ==========================================
  // Raster geometry
  wire        dblW = rasterMode_r[0];
  wire [11:0] colOff = dblW ? {rCol_r, 4'h0} : {1'b0, rCol_r, 3'h0};
  wire [19:0] dotX = {4'h0, leftMargin_r} + {8'h00, colOff};
  wire [19:0] dotEnd = dotX + (dblW ? 20'h00010 : 20'h00008);
  wire        inArea = dotEnd <= PD;
  wire        lastCol = ({8'h00, rCol_r} + 16'h0001) == rWidth_r;
  wire        lastRow = (rRow_r + 12'h001) == rasterRow_r;
  wire [15:0] rWidNew = {rxByte, rWidLo_r};
  wire [15:0] rHgtNew = {rxByte, rHgtLo_r};

  // ==========================================
  // Parser
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r       <= ST_IDLE;
      inRaster_r    <= 1'b0;
      cmd_r         <= 8'h00;
      symLen_r      <= 8'h00;
      symIdx_r      <= 8'h00;
      badData_r     <= 1'b0;
      rWidLo_r      <= 8'h00;
      rWidth_r      <= 16'h0000;
      rHgtLo_r      <= 8'h00;
      rCol_r        <= 8'h00;
      rRow_r        <= 12'h000;
      rDrop_r       <= 1'b0;
      rxReady_r     <= 1'b1;
      normByte_r    <= 8'h00;
      normValid_r   <= 1'b0;
      symStart_r    <= 1'b0;
      symType_r     <= 8'h00;
      symCount_r    <= 8'h00;
      symByte_r     <= 8'h00;
      symValid_r    <= 1'b0;
      feedReq_r     <= 1'b0;
      feedDots_r    <= 9'h000;
      homeReq_r     <= 1'b0;
      rasterDots_r  <= 8'h00;
      rasterX_r     <= 16'h0000;
      rasterRow_r   <= 12'h000;
      rasterMode_r  <= 2'h0;
      rasterValid_r <= 1'b0;
      hriFont_r     <= `BRCE_RST_FONT;
      hriBelow_r    <= `BRCE_RST_BELOW;
      barHeight_r   <= `BRCE_RST_HEIGHT;
      moduleWidth_r <= `BRCE_RST_WIDTH;
      leftMargin_r  <= `BRCE_RST_MARGIN;
      regRdata_r    <= 8'h00;
    end else begin
      normValid_r   <= 1'b0;
      symStart_r    <= 1'b0;
      symValid_r    <= 1'b0;
      feedReq_r     <= 1'b0;
      homeReq_r     <= 1'b0;
      rasterValid_r <= 1'b0;
      if (rasterData) begin
        if (take) begin
          // Off-paper bytes still drain so the stream stays aligned
          if (!rDrop_r && inArea) begin
            rasterDots_r  <= rxByte;
            rasterX_r     <= dotX[15:0];
            rasterValid_r <= 1'b1;
          end
          rCol_r <= lastCol ? 8'h00 : rCol_r + 8'h01;
          if (lastCol) begin
            rRow_r <= rRow_r + 12'h001;
            if (lastRow) begin
              inRaster_r <= 1'b0;
              state_r    <= ST_IDLE;
            end
          end
        end
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (take) begin
              if (rxByte == `BRCE_GS) begin
                state_r <= ST_GS;
              end else begin
                normByte_r  <= rxByte;
                normValid_r <= 1'b1;
              end
            end
          end
          ST_GS: begin
            if (take) begin
              cmd_r <= rxByte;
              case (rxByte)
                `BRCE_OP_FONT, `BRCE_OP_HEIGHT, `BRCE_OP_WIDTH, `BRCE_OP_POS: state_r <= ST_ARG;
                `BRCE_OP_MARGIN: state_r <= ST_MARGL;
                `BRCE_OP_SYMBOL: state_r <= ST_SYMM;
                `BRCE_OP_RASTER: state_r <= ST_V0;
                default: begin
                  normByte_r  <= rxByte;
                  normValid_r <= 1'b1;
                  state_r     <= ST_IDLE;
                end
              endcase
            end
          end
          ST_ARG: begin
            if (take) begin
              state_r <= ST_IDLE;
              case (cmd_r)
                `BRCE_OP_FONT:   if (rxByte[7:1] == 7'h00) hriFont_r <= rxByte[0];
                `BRCE_OP_HEIGHT: if (rxByte != 8'h00) barHeight_r <= rxByte;
                `BRCE_OP_WIDTH:  if ((rxByte >= `BRCE_WID_MIN) && (rxByte <= `BRCE_WID_MAX))
                  moduleWidth_r <= rxByte[2:0];
                default:         if ((rxByte == 8'h00) || (rxByte == 8'h02)) hriBelow_r <= rxByte[1];
              endcase
            end
          end
          ST_MARGL: begin
            if (take) begin
              leftMargin_r[7:0] <= rxByte;
              state_r           <= ST_MARGH;
            end
          end
          ST_MARGH: begin
            if (take) begin
              leftMargin_r[15:8] <= rxByte;
              state_r            <= ST_IDLE;
            end
          end
          ST_SYMM: begin
            if (take) begin
              symType_r <= rxByte;
              // Pending text means everything after the type byte is text
              state_r <= (bufEmpty && ((rxByte == `BRCE_SYM_EAN13) || (rxByte == `BRCE_SYM_CODE39) ||
                          (rxByte == `BRCE_SYM_ITF))) ? ST_SYMN : ST_IDLE;
            end
          end
          ST_SYMN: begin
            if (take) begin
              symLen_r  <= rxByte;
              symIdx_r  <= 8'h00;
              badData_r <= 1'b0;
              state_r   <= ((rxByte == 8'h00) || ((symType_r == `BRCE_SYM_EAN13) &&
                            ((rxByte < `BRCE_EAN_MIN) || (rxByte > `BRCE_EAN_MAX)))) ? ST_IDLE : ST_SYMD;
            end
          end
          ST_SYMD: begin
            if (take) begin
              symMem[symIdx_r] <= rxByte;
              // Odd trailing ITF byte is outside effLen and never checked
              if (!charOk(symType_r, rxByte) && (symIdx_r < effLen)) begin
                badData_r <= 1'b1;
              end
              symIdx_r <= symIdx_r + 8'h01;
              if (symIdx_r + 8'h01 == symLen_r) begin
                rxReady_r <= 1'b0;
                state_r   <= ST_CHK;
              end
            end
          end
          ST_CHK: begin
            symIdx_r   <= 8'h00;
            feedDots_r <= symFeed;
            if (badData_r || tooWide || (effLen == 8'h00)) begin
              feedReq_r <= 1'b1;
              rxReady_r <= 1'b1;
              state_r   <= ST_IDLE;
            end else begin
              // Symbol bypasses print modes; text always at 1x1
              symCount_r <= effLen;
              symStart_r <= 1'b1;
              state_r    <= ST_OUT;
            end
          end
          ST_OUT: begin
            symByte_r  <= symMem[symIdx_r];
            symValid_r <= 1'b1;
            symIdx_r   <= symIdx_r + 8'h01;
            if (symIdx_r + 8'h01 == symCount_r) begin
              feedReq_r <= 1'b1;
              homeReq_r <= 1'b1;
              rxReady_r <= 1'b1;
              state_r   <= ST_IDLE;
            end
          end
          ST_V0: if (take) state_r <= (rxByte == `BRCE_OP_RASTER0) ? ST_RM : ST_IDLE;
          ST_RM: begin
            if (take) begin
              rasterMode_r <= rxByte[1:0];
              state_r      <= (rxByte <= `BRCE_RMODE_MAX) ? ST_RXL : ST_IDLE;
            end
          end
          ST_RXL: begin
            if (take) begin
              rWidLo_r <= rxByte;
              state_r  <= ST_RXH;
            end
          end
          ST_RXH: begin
            if (take) begin
              rWidth_r <= rWidNew;
              state_r  <= ((rWidNew == 16'h0000) || (rWidNew > `BRCE_RWID_MAX)) ? ST_IDLE : ST_RYL;
            end
          end
          ST_RYL: begin
            if (take) begin
              rHgtLo_r <= rxByte;
              state_r  <= ST_RYH;
            end
          end
          ST_RYH: begin
            if (take) begin
              rasterRow_r <= rHgtNew[11:0];
              rCol_r      <= 8'h00;
              rRow_r      <= 12'h000;
              // Busy buffer: image is drained but never printed
              rDrop_r     <= !bufEmpty;
              if ((rHgtNew == 16'h0000) || (rxByte > `BRCE_RHGT_HMAX) ||
                  (rHgtNew > `BRCE_RHGT_MAX)) begin
                state_r <= ST_IDLE;
              end else begin
                inRaster_r <= 1'b1;
                state_r    <= ST_RDAT;
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
      // Software writes land after the parser so they win a tie
      if (regWr) begin
        case (regAddr)
          `BRCE_REG_FONT:   hriFont_r <= regWdata[0];
          `BRCE_REG_HEIGHT: if (regWdata != 8'h00) barHeight_r <= regWdata;
          `BRCE_REG_WIDTH:  if ((regWdata >= `BRCE_WID_MIN) && (regWdata <= `BRCE_WID_MAX))
            moduleWidth_r <= regWdata[2:0];
          `BRCE_REG_POS:    hriBelow_r <= regWdata[1];
          `BRCE_REG_MARG_L: leftMargin_r[7:0] <= regWdata;
          `BRCE_REG_MARG_H: leftMargin_r[15:8] <= regWdata;
          default: ;
        endcase
      end
      if (regRd) begin
        case (regAddr)
          `BRCE_REG_STATUS: regRdata_r <= {errState_r, inRaster_r, bufEmpty, 1'b0, state_r};
          `BRCE_REG_FONT:   regRdata_r <= {7'h00, hriFont_r};
          `BRCE_REG_HEIGHT: regRdata_r <= barHeight_r;
          `BRCE_REG_WIDTH:  regRdata_r <= {5'h00, moduleWidth_r};
          `BRCE_REG_POS:    regRdata_r <= {6'h00, hriBelow_r, 1'b0};
          `BRCE_REG_MARG_L: regRdata_r <= leftMargin_r[7:0];
          `BRCE_REG_MARG_H: regRdata_r <= leftMargin_r[15:8];
          default:          regRdata_r <= 8'h00;
        endcase
      end else begin
        regRdata_r <= 8'h00;
      end
    end
  end

  // ==========================================
  // Cutter recovery
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lockSync_r   <= 2'h0;
      homeSync_r   <= 2'h0;
      errState_r   <= 1'b0;
      recoverReq_r <= 1'b0;
    end else begin
      lockSync_r   <= {lockSync_r[0], cutterLocked};
      homeSync_r   <= {homeSync_r[0], cutterHome};
      recoverReq_r <= 1'b0;
      // Lock beats home if both are seen together
      if (lockSync_r[1] && !errState_r) begin
        errState_r   <= 1'b1;
        recoverReq_r <= 1'b1;
      end else if (homeSync_r[1] && !lockSync_r[1]) begin
        errState_r <= 1'b0;
      end
    end
  end

endmodule

// ### verif/brce_chk.sv
// Concurrent checks on the command engine ports
module brce_chk #(
  parameter PRINT_DOTS = 576
) (
  input wire        clk,
  input wire        rst_b,
  input wire        rxReady_r,
  input wire        cutterLocked,
  input wire        symStart_r,
  input wire [7:0]  symType_r,
  input wire [7:0]  symCount_r,
  input wire        symValid_r,
  input wire        feedReq_r,
  input wire [8:0]  feedDots_r,
  input wire        homeReq_r,
  input wire [15:0] rasterX_r,
  input wire [1:0]  rasterMode_r,
  input wire        rasterValid_r,
  input wire        hriFont_r,
  input wire        hriBelow_r,
  input wire [7:0]  barHeight_r,
  input wire [2:0]  moduleWidth_r,
  input wire [15:0] leftMargin_r,
  input wire        errState_r,
  input wire        recoverReq_r,
  input wire [3:0]  regAddr,
  input wire        regRd,
  input wire [7:0]  regRdata_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Settings
  a_rd_height: assert property (regRd && regAddr == 4'h2 |=> regRdata_r == $past(barHeight_r))
    else $error("height read back wrong");
  a_height_live: assert property (barHeight_r != 8'h00)
    else $error("zero symbol height");
  a_width_range: assert property (moduleWidth_r inside {[3'h2:3'h6]})
    else $error("module width out of range");
  // ==========================================
  // Symbols
  a_sym_type: assert property (symStart_r |-> symType_r inside {8'h43, 8'h45, 8'h46})
    else $error("unknown symbology started");
  a_sym_first: assert property (symStart_r |-> !rxReady_r ##1 symValid_r)
    else $error("symbol data did not follow start");
  a_itf_even: assert property (symStart_r && symType_r == 8'h46 |-> !symCount_r[0])
    else $error("odd interleaved count");
  a_feed_home: assert property (homeReq_r |-> feedReq_r)
    else $error("line start without feed");
  a_feed_dots: assert property (homeReq_r |-> feedDots_r == barHeight_r + (hriBelow_r ? (hriFont_r ? 9'h010 : 9'h018) : 9'h000))
    else $error("feed amount wrong");
  // ==========================================
  // Raster, cutter and covers
  a_raster_fit: assert property (rasterValid_r |-> rasterX_r + (rasterMode_r[0] ? 16 : 8) <= PRINT_DOTS)
    else $error("raster byte past print width");
  a_raster_margin: assert property (rasterValid_r |-> rasterX_r >= leftMargin_r)
    else $error("raster byte left of margin");
  a_cut_recover: assert property ($rose(cutterLocked) && !errState_r |-> ##[1:4] (errState_r && recoverReq_r))
    else $error("no cutter recovery");
  c_symbol: cover property (symStart_r);
  c_quad: cover property (rasterValid_r && rasterMode_r == 2'h3);
  c_recover: cover property (recoverReq_r);
endmodule

// ### verif/brce_host.sv
// Host model feeding the command byte stream
module brce_host (
  input wire         clk,
  input wire         rxReady_r,
  output logic [7:0] rxByte,
  output logic       rxValid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
  end
  // ==========================================
  // Byte held until the engine takes it
  task automatic send(input logic [7:0] b, input int gap);
    int i;
    rxByte <= b;
    rxValid <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rxReady_r !== 1'b1 && i < 400);
    if (i >= 400) tb_top.complete_run(1);
    if (gap > 0) begin
      quiet(b);
      repeat (gap - 1) @(posedge clk);
    end
  endtask
  // Idle line shows the inverse so a stale byte never looks valid
  task automatic quiet(input logic [7:0] b);
    rxValid <= 1'b0;
    rxByte <= ~b;
    @(posedge clk);
  endtask
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the bar code and raster engine
`include "brce_regs.vh"
`define CHK(g, w) begin nChecks++; if ((g) !== (w)) begin miscompares++; $display("BAD %0t got %h want %h", $time, g, w); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, bufEmpty, cutterLocked, cutterHome, regWr, regRd, rxValid, rxReady_r;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata_r, rxByte, normByte_r, symType_r, symCount_r, symByte_r, barHeight_r, rasterDots_r;
  logic        normValid_r, symStart_r, symValid_r, feedReq_r, homeReq_r, rasterValid_r, hriFont_r, hriBelow_r;
  logic        errState_r, recoverReq_r;
  logic [8:0]  feedDots_r, lastFeed;
  logic [15:0] rasterX_r, leftMargin_r;
  logic [11:0] rasterRow_r;
  logic [1:0]  rasterMode_r;
  logic [2:0]  moduleWidth_r;
  logic [7:0]  q[$], normQ[$], symQ[$], r, h;
  logic [23:0] rasQ[$];
  int          seed, nChecks, miscompares, nStart, nFeed, nHome, i;
  logic [7:0]  rAddr[7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f};
  logic [7:0]  rVal[7] = '{8'h00, 8'ha2, 8'h03, 8'h02, 8'h00, 8'h00, 8'h00};
  brce_engine #(.PRINT_DOTS(576)) DUT (.clk, .rst_b, .rxByte, .rxValid, .rxReady_r, .bufEmpty, .cutterLocked,
    .cutterHome, .normByte_r, .normValid_r, .symStart_r, .symType_r, .symCount_r, .symByte_r, .symValid_r,
    .feedReq_r, .feedDots_r, .homeReq_r, .rasterDots_r, .rasterX_r, .rasterRow_r, .rasterMode_r, .rasterValid_r,
    .hriFont_r, .hriBelow_r, .barHeight_r, .moduleWidth_r, .leftMargin_r, .errState_r, .recoverReq_r, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata_r);
  brce_host uHost (.clk, .rxReady_r, .rxByte, .rxValid);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================
  // Output monitor
  always @(posedge clk) begin
    if (normValid_r === 1'b1) normQ.push_back(normByte_r);
    if (symValid_r === 1'b1) symQ.push_back(symByte_r);
    if (rasterValid_r === 1'b1) rasQ.push_back({rasterX_r, rasterDots_r});
    if (symStart_r === 1'b1) nStart++;
    if (feedReq_r === 1'b1) begin
      nFeed++;
      lastFeed = feedDots_r;
    end
    if (feedReq_r === 1'b1 && homeReq_r === 1'b1) nHome++;
  end
  // ==========================================
  // Tasks and expectations
  task automatic complete_run(input int hang);
    miscompares += hang;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic regRead(input logic [3:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    d = regRdata_r;
  endtask
  // Random gaps make the host both prompt and slow
  task automatic put(input logic [7:0] s[$]);
    int k;
    normQ.delete(); symQ.delete(); rasQ.delete();
    nStart = 0; nFeed = 0; nHome = 0;
    foreach (s[j]) uHost.send(s[j], $unsigned($random(seed)) % 3);
    uHost.quiet(s[s.size() - 1]);
    k = 0;
    while (rxReady_r !== 1'b1 && k < 600) begin
      @(posedge clk);
      k++;
    end
    if (k >= 600) complete_run(1);
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [15:0] rasX(logic [1:0] m, int col);
    return 16'h0008 + 16'(col) * (m[0] ? 16'h0010 : 16'h0008);
  endfunction
  // ==========================================
  // Main sequence
  initial begin
    seed = 62;
    rst_b = 1'b0; bufEmpty = 1'b1; cutterLocked = 1'b0; cutterHome = 1'b0;
    regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0; regWdata = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    regWrite(4'hf, 8'h5a);
    for (i = 0; i < 7; i++) begin
      regRead(rAddr[i][3:0], r);
      `CHK(r, rVal[i])
    end
    put('{8'h1d, 8'h66, 8'h01, 8'h1d, 8'h68, 8'h00, 8'h1d, 8'h77, 8'h07, 8'h1d, 8'h48, 8'h02});
    `CHK({hriFont_r, barHeight_r, moduleWidth_r}, {1'b1, 8'ha2, 3'h3})
    for (i = 2; i <= 6; i++) begin
      h = $random(seed);
      h[0] = 1'b1;
      put('{8'h1d, 8'h68, h, 8'h1d, 8'h77, 8'(i)});
      `CHK({barHeight_r, moduleWidth_r}, {h, 3'(i)})
    end
    regWrite(4'h3, 8'h02);
    q = '{8'h1d, 8'h6b, 8'h45, 8'h04};
    for (i = 0; i < 4; i++) q.push_back(8'h41 + 8'($unsigned($random(seed)) % 26));
    put(q);
    `CHK({nStart, nFeed, nHome, symType_r, symCount_r}, {32'd1, 32'd1, 32'd1, 8'h45, 8'h04})
    `CHK(symQ == q[4:7], 1'b1)
    `CHK(lastFeed, 9'(h) + 9'h010)
    put('{8'h1d, 8'h66, 8'h00, 8'h1d, 8'h48, 8'h00, 8'h1d, 8'h6b, 8'h46, 8'h03, 8'h31, 8'h32, 8'h33});
    `CHK({symCount_r, symQ.size(), lastFeed}, {8'h02, 32'd2, 9'(h)})
    q = '{8'h1d, 8'h48, 8'h02, 8'h1d, 8'h6b, 8'h43, 8'h0d};
    for (i = 0; i < 13; i++) q.push_back(8'h30 + 8'(i % 10));
    put(q);
    `CHK({nStart, symCount_r, lastFeed}, {32'd1, 8'h0d, 9'(h) + 9'h018})
    put('{8'h1d, 8'h6b, 8'h43, 8'h0b, 8'h41});
    `CHK({nStart, normQ[$]}, {32'd0, 8'h41})
    put('{8'h1d, 8'h6b, 8'h45, 8'h02, 8'h41, 8'h61, 8'h42});
    `CHK({nStart, nFeed, normQ[$]}, {32'd0, 32'd1, 8'h42})
    regWrite(4'h3, 8'h06);
    put('{8'h1d, 8'h6b, 8'h45, 8'h08, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41});
    `CHK({nStart, nFeed}, {32'd0, 32'd1})
    bufEmpty <= 1'b0;
    put('{8'h1d, 8'h6b, 8'h45, 8'h41});
    `CHK({nStart, normQ.size(), normQ[0]}, {32'd0, 32'd1, 8'h41})
    put('{8'h1d, 8'h76, 8'h30, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'hff, 8'h33});
    `CHK({rasQ.size(), normQ[$]}, {32'd0, 8'h33})
    bufEmpty <= 1'b1;
    put('{8'h1d, 8'h4c, 8'h08, 8'h00});
    `CHK(leftMargin_r, 16'h0008)
    for (i = 0; i < 4; i++) begin
      q = '{8'h1d, 8'h76, 8'h30, 8'(i), 8'h02, 8'h00, 8'h02, 8'h00};
      repeat (4) q.push_back(8'($random(seed)));
      put(q);
      `CHK({rasQ.size(), rasterMode_r, rasterRow_r}, {32'd4, 2'(i), 12'h002})
      foreach (rasQ[j]) `CHK(rasQ[j], {rasX(2'(i), j % 2), q[8 + j]})
    end
    q = '{8'h1d, 8'h76, 8'h30, 8'h01, 8'h50, 8'h00, 8'h01, 8'h00};
    repeat (80) q.push_back(8'($random(seed)));
    q.push_back(8'h5a);
    put(q);
    `CHK({rasQ.size(), normQ[$]}, {32'd35, 8'h5a})
    cutterLocked <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(errState_r, 1'b1)
    regRead(4'h0, r);
    `CHK(r, 8'ha0)
    cutterLocked <= 1'b0;
    cutterHome <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(errState_r, 1'b0)
    complete_run(0);
  end
endmodule
bind brce_engine brce_chk #(.PRINT_DOTS(PRINT_DOTS)) uChk (.clk, .rst_b, .rxReady_r, .cutterLocked, .symStart_r,
  .symType_r, .symCount_r, .symValid_r, .feedReq_r, .feedDots_r, .homeReq_r, .rasterX_r, .rasterMode_r,
  .rasterValid_r, .hriFont_r, .hriBelow_r, .barHeight_r, .moduleWidth_r, .leftMargin_r, .errState_r,
  .recoverReq_r, .regAddr, .regRd, .regRdata_r);
